// ===== test/can_bus_model.sv
`timescale 1ns/100ps
// local driver and one far node on a shared bus
module can_bus_model (
  input wire logic drive_dominant,
  input wire logic drive_enable,
  input wire logic far_dominant,
  output logic rx_level,
  output logic monitor_level
);
  logic dom;
  // dominant overrides recessive and reads as logic low
  assign dom = (drive_enable & drive_dominant) | far_dominant;
  assign rx_level = ~dom;
  assign monitor_level = ~dom;
endmodule : can_bus_model

// ===== test/can_transceiver_mode_wake_control_tb_top.sv
`timescale 1ns/100ps
module can_transceiver_mode_wake_control_tb_top;
  import xcvr_pkg::*;
  logic clk = 0, rstn = 0, txd = 1, txd_drv = 1, sel = 0, sel_drv = 1;
  logic hot = 0, main_low = 0, io_low = 1, far_dom = 0, ce = 1;
  logic rx_lvl, mon_lvl, drv_dom, drv_en, rxd, oe_n, b_mid, b_gnd, rx_en, mon_en;
  mode_t mode;
  int mismatches = 0, n_compared = 0, tn = 0;
  logic [31:0] seed = 32'h3e;
  always #50 clk = ~clk;
  can_mode_wake_ctrl #(.DOM_LIMIT_CYCLES(20), .WAKE_WINDOW(200), .MODE_WAIT_CYCLES(5),
    .FILTER_CYCLES(3)) uut (.clk(clk), .rstn(rstn), .clk_en(ce), .txd_in(txd),
    .txd_driven(txd_drv), .standby_select(sel), .standby_select_driven(sel_drv),
    .thermal_shutdown(hot), .main_supply_low(main_low), .io_supply_low(io_low),
    .bus_rx_level(rx_lvl), .bus_monitor_level(mon_lvl), .bus_drive_dominant(drv_dom),
    .driver_enable(drv_en), .bias_mid(b_mid), .bias_ground(b_gnd), .main_rx_enable(rx_en),
    .monitor_enable(mon_en), .rxd_out(rxd), .rxd_oe_n(oe_n), .mode(mode));
  can_bus_model bus_i (.drive_dominant(drv_dom), .drive_enable(drv_en),
    .far_dominant(far_dom), .rx_level(rx_lvl), .monitor_level(mon_lvl));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // expected transmit drive and receive level in normal mode
  function automatic logic exp_drive(logic drv, logic t);
    return drv & ~t;
  endfunction : exp_drive
  function automatic logic exp_rx(logic drv, logic t, logic f);
    return ~(f | exp_drive(drv, t));
  endfunction : exp_rx
  task automatic chk(logic g, logic e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: bit %b want %b", $time, g, e);
    end
  endtask : chk
  task automatic chk_mode(mode_t g, mode_t e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: mode %0d want %0d", $time, g, e);
    end
  endtask : chk_mode
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic bus(logic d, int n);
    far_dom = d;
    cyc(n);
  endtask : bus
  task automatic done();
    tn++;
    $display("test %0d finished", tn);
  endtask : done
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // watchdog against a hung sequence
  initial begin
    repeat (6000) @(posedge clk);
    mismatches++;
    summarize();
  end
  // main sequence, inputs changed at the falling edge
  initial begin
    cyc(10);
    rstn = 1'h1;
    cyc(2);
    chk(oe_n, 1'h1);
    chk_mode(mode, MODE_PROTECTED);
    io_low = 1'h0;
    cyc(2);
    chk_mode(mode, MODE_WAIT);
    cyc(8);
    chk_mode(mode, MODE_NORMAL);
    chk(rx_en, 1'h1);
    chk(b_gnd, 1'h0);
    for (int i = 0; i < 150; i++) begin
      seed = xs(seed);
      txd = seed[0] | (i % 4 == 0);
      txd_drv = seed[1] | seed[2];
      far_dom = seed[3] & seed[4];
      cyc(2);
      chk(drv_dom, exp_drive(txd_drv, txd));
      chk(rxd, exp_rx(txd_drv, txd, far_dom));
    end
    done();
    txd = 1'h0;
    txd_drv = 1'h1;
    far_dom = 1'h0;
    cyc(30);
    chk(drv_en, 1'h0);
    chk(rxd, RECESSIVE);
    txd = 1'h1;
    cyc(3);
    chk(drv_en, 1'h1);
    hot = 1'h1;
    txd = 1'h0;
    cyc(2);
    chk(drv_en, 1'h0);
    chk(rxd, RECESSIVE);
    bus(1'h1, 2);
    chk(rxd, DOMINANT);
    chk(b_mid, 1'h1);
    far_dom = 1'h0;
    hot = 1'h0;
    cyc(2);
    chk(rxd, DOMINANT);
    txd = 1'h1;
    done();
    sel = 1'h1;
    cyc(2);
    chk_mode(mode, MODE_STANDBY);
    chk(b_gnd, 1'h1);
    chk(mon_en, 1'h1);
    chk(rx_en, 1'h0);
    repeat (5) begin
      bus(1'h1, 2);
      bus(1'h0, 3);
    end
    chk(rxd, RECESSIVE);
    bus(1'h1, 8);
    bus(1'h0, 8);
    bus(1'h1, 1);
    bus(1'h0, 8);
    bus(1'h1, 10);
    chk(rxd, DOMINANT);
    bus(1'h0, 5);
    chk(rxd, RECESSIVE);
    ce = 1'h0;
    bus(1'h1, 10);
    chk(rxd, RECESSIVE);
    ce = 1'h1;
    bus(1'h1, 10);
    chk(rxd, DOMINANT);
    bus(1'h0, 5);
    sel_drv = 1'h0;
    sel = 1'h0;
    cyc(2);
    chk_mode(mode, MODE_STANDBY);
    sel_drv = 1'h1;
    cyc(2);
    chk_mode(mode, MODE_NORMAL);
    done();
    sel = 1'h1;
    cyc(2);
    bus(1'h1, 8);
    bus(1'h0, 250);
    bus(1'h1, 10);
    chk(rxd, RECESSIVE);
    bus(1'h0, 5);
    main_low = 1'h1;
    cyc(2);
    chk_mode(mode, MODE_STANDBY);
    sel = 1'h0;
    cyc(2);
    chk_mode(mode, MODE_PROTECTED);
    chk(rxd, RECESSIVE);
    chk(oe_n, 1'h0);
    main_low = 1'h0;
    cyc(12);
    chk_mode(mode, MODE_NORMAL);
    done();
    summarize();
  end
endmodule : can_transceiver_mode_wake_control_tb_top

// ===== test/mode_wake_checker_assertions.sv
`timescale 1ns/100ps
// port-level temporal checks of the mode and wake control
module mode_wake_checker #(
  parameter int unsigned DOM_LIMIT_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic txd_in,
  input wire logic txd_driven,
  input wire logic standby_select,
  input wire logic standby_select_driven,
  input wire logic thermal_shutdown,
  input wire logic main_supply_low,
  input wire logic io_supply_low,
  input wire logic bus_rx_level,
  input wire logic bus_monitor_level,
  input wire logic bus_drive_dominant,
  input wire logic driver_enable,
  input wire logic bias_mid,
  input wire logic bias_ground,
  input wire logic main_rx_enable,
  input wire logic monitor_enable,
  input wire logic rxd_out,
  input wire logic rxd_oe_n,
  input wire xcvr_pkg::mode_t mode
);
  import xcvr_pkg::*;
  int unsigned dom_cnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // counts consecutive cycles of effective transmit dominant in normal mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) dom_cnt_q <= 0;
    else if (mode == MODE_NORMAL && txd_driven && !txd_in) dom_cnt_q <= dom_cnt_q + 1;
    else dom_cnt_q <= 0;
  end
  a_shutdown_driver_off: assert property (thermal_shutdown |=> !driver_enable && !bus_drive_dominant)
    else $error("driver active in shutdown");
  a_normal_bias: assert property (mode == MODE_NORMAL |-> bias_mid && main_rx_enable)
    else $error("normal bias or receiver off");
  a_uv_protect: assert property (io_supply_low |=> mode == MODE_PROTECTED && rxd_oe_n)
    else $error("io low not protected");
  a_split_standby: assert property (main_supply_low && !io_supply_low && standby_select
    && standby_select_driven |=> mode == MODE_STANDBY && bias_ground)
    else $error("split standby wrong");
  a_standby_quiet: assert property (mode == MODE_STANDBY |-> !driver_enable && monitor_enable
    && !main_rx_enable && bias_ground && !bias_mid)
    else $error("standby outputs wrong");
  a_wait_first: assert property ($rose(mode == MODE_WAIT) |-> (mode != MODE_NORMAL) [*4])
    else $error("wait too short");
  a_no_skip: assert property (mode == MODE_PROTECTED |=> mode != MODE_NORMAL)
    else $error("protected went normal");
  a_rx_mirror: assert property (mode == MODE_NORMAL && $past(mode) == MODE_NORMAL
    |-> rxd_out == $past(bus_rx_level) && !rxd_oe_n)
    else $error("rxd not mirroring bus");
  a_tx_path: assert property (mode == MODE_NORMAL && $past(mode) == MODE_NORMAL && driver_enable
    |-> bus_drive_dominant == ($past(txd_driven) && !$past(txd_in)))
    else $error("transmit path wrong");
  a_timeout_cut: assert property (dom_cnt_q > DOM_LIMIT_CYCLES + 2 |-> !driver_enable)
    else $error("dominant timeout missed");
  a_select_mode: assert property (!main_supply_low && !io_supply_low
    && (standby_select || !standby_select_driven) |=> mode == MODE_STANDBY)
    else $error("select high not standby");
endmodule : mode_wake_checker
bind can_mode_wake_ctrl mode_wake_checker #(.DOM_LIMIT_CYCLES(DOM_LIMIT_CYCLES)) chk (
  .clk(clk), .rstn(rstn), .clk_en(clk_en), .txd_in(txd_in), .txd_driven(txd_driven),
  .standby_select(standby_select), .standby_select_driven(standby_select_driven),
  .thermal_shutdown(thermal_shutdown), .main_supply_low(main_supply_low),
  .io_supply_low(io_supply_low), .bus_rx_level(bus_rx_level),
  .bus_monitor_level(bus_monitor_level), .bus_drive_dominant(bus_drive_dominant),
  .driver_enable(driver_enable), .bias_mid(bias_mid), .bias_ground(bias_ground),
  .main_rx_enable(main_rx_enable), .monitor_enable(monitor_enable), .rxd_out(rxd_out),
  .rxd_oe_n(rxd_oe_n), .mode(mode));

// ===== verilog/bus_state_filter.sv
`timescale 1ns/100ps
// qualifies a bus level that persists longer than the filter time
module bus_state_filter #(
  parameter int unsigned FILTER_CYCLES = xcvr_pkg::WAKE_FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic enable,
  input wire logic bus_level,
  state_filter_if.source filt
);
  import xcvr_pkg::*;
  // refuse filter lengths that the 16-bit counter cannot hold
  if (FILTER_CYCLES < 1 || FILTER_CYCLES > 65534) begin : g_bad_filter
    $error("bad filter length");
  end
  typedef struct packed {
    logic prev;
    logic [15:0] cnt;
    logic fired;
  } filt_state_t;
  filt_state_t s_q, s_d;
  // count restarts on each level change; event once the count passes the filter
  always_comb begin
    s_d = s_q;
    filt.filt_dom = 1'b0;
    filt.filt_rec = 1'b0;
    filt.dom_level = 1'b0;
    if (!enable) begin
      s_d.cnt = '0;
      s_d.fired = 1'b0;
      s_d.prev = RECESSIVE;
    end else if (bus_level != s_q.prev) begin
      s_d.prev = bus_level;
      s_d.cnt = '0;
      s_d.fired = 1'b0;
    end else if (!s_q.fired) begin
      if (s_q.cnt >= 16'(FILTER_CYCLES)) begin
        s_d.fired = 1'b1;
        filt.filt_dom = (bus_level == DOMINANT);
        filt.filt_rec = (bus_level == RECESSIVE);
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end
    filt.dom_level = enable && s_q.fired && (s_q.prev == DOMINANT);
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{prev: 1'b1, cnt: 16'h0000, fired: 1'b0};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end
endmodule : bus_state_filter

// ===== verilog/can_mode_wake_ctrl.sv
`timescale 1ns/100ps
// mode, protection and wake control of a high-speed bus transceiver
module can_mode_wake_ctrl #(
  parameter int unsigned DOM_LIMIT_CYCLES = xcvr_pkg::TRANSMIT_DOMINANT_CYCLES,
  parameter int unsigned WAKE_WINDOW = xcvr_pkg::WAKE_WINDOW_CYCLES,
  parameter int unsigned MODE_WAIT_CYCLES = xcvr_pkg::MODE_CYCLES,
  parameter int unsigned FILTER_CYCLES = xcvr_pkg::WAKE_FILTER_CYCLES,
  parameter bit SPLIT_SUPPLY = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic txd_in,
  input wire logic txd_driven,
  input wire logic standby_select,
  input wire logic standby_select_driven,
  input wire logic thermal_shutdown,
  input wire logic main_supply_low,
  input wire logic io_supply_low,
  input wire logic bus_rx_level,
  input wire logic bus_monitor_level,
  output logic bus_drive_dominant,
  output logic driver_enable,
  output logic bias_mid,
  output logic bias_ground,
  output logic main_rx_enable,
  output logic monitor_enable,
  output logic rxd_out,
  output logic rxd_oe_n,
  output xcvr_pkg::mode_t mode
);
  import xcvr_pkg::*;
  // refuse counts that the 24-bit counters cannot hold
  if (DOM_LIMIT_CYCLES < 1 || DOM_LIMIT_CYCLES >= 2 ** 24) begin : g_bad_dom_limit
    $error("bad dominant limit");
  end
  if (WAKE_WINDOW < 1 || WAKE_WINDOW >= 2 ** 24) begin : g_bad_wake_window
    $error("bad wake window");
  end
  if (MODE_WAIT_CYCLES < 1 || MODE_WAIT_CYCLES >= 2 ** 24) begin : g_bad_mode_time
    $error("bad mode time");
  end
  typedef struct packed {
    mode_t mode;
    wake_state_t wake;
    logic [23:0] mode_cnt;
    logic [23:0] win_cnt;
    logic [23:0] dom_cnt;
    logic dom_fault;
    logic txd_prev;
    logic rxd;
    logic drv_en;
    logic drv_dom;
    logic rxd_oe_n;
    logic mid;
    logic gnd;
    logic rx_en;
    logic mon_en;
  } ctrl_state_t;
  ctrl_state_t s_q, s_d;
  logic txd_eff;
  logic select_eff;
  logic uv_protect;
  logic standby_ok;
  state_filter_if filt_bus ();
  // floating pins fall back to their weak pull-ups
  assign txd_eff = txd_driven ? txd_in : RECESSIVE;
  assign select_eff = standby_select_driven ? standby_select : 1'b1;
  // protected state for any low supply; split-supply standby stays available
  assign standby_ok = SPLIT_SUPPLY && main_supply_low && !io_supply_low && select_eff;
  assign uv_protect = (main_supply_low || io_supply_low) && !standby_ok;
  bus_state_filter #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_filter (
    .clk(clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .enable(s_q.mode == MODE_STANDBY),
    .bus_level(bus_monitor_level),
    .filt(filt_bus.source)
  );
  // next-state logic for mode, wake detector and dominant timeout
  always_comb begin
    s_d = s_q;
    s_d.txd_prev = txd_eff;
    unique case (s_q.mode)
      MODE_PROTECTED: begin
        if (!uv_protect) begin
          s_d.mode = select_eff ? MODE_STANDBY : MODE_WAIT;
          s_d.mode_cnt = '0;
        end
      end
      MODE_STANDBY: begin
        if (uv_protect) begin
          s_d.mode = MODE_PROTECTED;
        end else if (!select_eff && !main_supply_low) begin
          s_d.mode = MODE_NORMAL;
        end
      end
      MODE_WAIT: begin
        if (uv_protect) begin
          s_d.mode = MODE_PROTECTED;
        end else if (select_eff) begin
          s_d.mode = MODE_STANDBY;
        end else if (s_q.mode_cnt >= 24'(MODE_WAIT_CYCLES - 1)) begin
          s_d.mode = MODE_NORMAL;
        end else begin
          s_d.mode_cnt = s_q.mode_cnt + 24'h000001;
        end
      end
      MODE_NORMAL: begin
        if (uv_protect) begin
          s_d.mode = MODE_PROTECTED;
        end else if (select_eff) begin
          s_d.mode = MODE_STANDBY;
        end
      end
    endcase
    // wake pattern detector, active only in standby
    if (s_q.mode != MODE_STANDBY) begin
      s_d.wake = WAKE_IDLE;
      s_d.win_cnt = '0;
    end else begin
      unique case (s_q.wake)
        WAKE_IDLE: begin
          if (filt_bus.filt_dom) begin
            s_d.wake = WAKE_SEEK_REC;
            s_d.win_cnt = '0;
          end
        end
        WAKE_SEEK_REC, WAKE_SEEK_DOM: begin
          if (s_q.win_cnt >= 24'(WAKE_WINDOW - 1)) begin
            s_d.wake = WAKE_IDLE;
          end else begin
            s_d.win_cnt = s_q.win_cnt + 24'h000001;
            if (s_q.wake == WAKE_SEEK_REC && filt_bus.filt_rec) begin
              s_d.wake = WAKE_SEEK_DOM;
            end else if (s_q.wake == WAKE_SEEK_DOM && filt_bus.filt_dom) begin
              s_d.wake = WAKE_DONE;
            end
          end
        end
        WAKE_DONE: begin
          s_d.wake = WAKE_DONE;
        end
      endcase
    end
    // dominant timeout: falling edge starts, recessive clears
    if (s_q.mode != MODE_NORMAL || txd_eff == RECESSIVE) begin
      s_d.dom_cnt = '0;
      s_d.dom_fault = 1'b0;
    end else if (s_q.txd_prev == RECESSIVE) begin
      s_d.dom_cnt = '0;
    end else if (!s_q.dom_fault) begin
      if (s_q.dom_cnt >= 24'(DOM_LIMIT_CYCLES - 1)) begin
        s_d.dom_fault = 1'b1;
      end else begin
        s_d.dom_cnt = s_q.dom_cnt + 24'h000001;
      end
    end
    // pin and bias outputs per next mode
    s_d.drv_en = 1'b0;
    s_d.drv_dom = 1'b0;
    s_d.mid = 1'b0;
    s_d.gnd = 1'b0;
    s_d.rx_en = 1'b0;
    s_d.mon_en = 1'b0;
    s_d.rxd = RECESSIVE;
    s_d.rxd_oe_n = 1'b0;
    unique case (s_d.mode)
      MODE_PROTECTED: begin
        s_d.rxd_oe_n = main_supply_low && !io_supply_low ? 1'b0 : 1'b1;
      end
      MODE_STANDBY: begin
        s_d.gnd = 1'b1;
        s_d.mon_en = 1'b1;
        if (s_d.wake == WAKE_DONE) begin
          s_d.rxd = (s_q.wake == WAKE_DONE && filt_bus.dom_level) ? DOMINANT : RECESSIVE;
        end
      end
      MODE_WAIT: begin
        s_d.mid = 1'b1;
      end
      MODE_NORMAL: begin
        s_d.mid = 1'b1;
        s_d.rx_en = 1'b1;
        s_d.rxd = bus_rx_level;
        s_d.drv_en = !thermal_shutdown && !s_d.dom_fault;
        s_d.drv_dom = s_d.drv_en && (txd_eff == DOMINANT);
      end
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{mode: MODE_PROTECTED, wake: WAKE_IDLE, mode_cnt: 24'h000000,
               win_cnt: 24'h000000, dom_cnt: 24'h000000, dom_fault: 1'b0,
               txd_prev: 1'b1, rxd: 1'b1, drv_en: 1'b0, drv_dom: 1'b0,
               rxd_oe_n: 1'b1, mid: 1'b0, gnd: 1'b0, rx_en: 1'b0, mon_en: 1'b0};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end
  // outputs straight from the state register
  assign bus_drive_dominant = s_q.drv_dom;
  assign driver_enable = s_q.drv_en;
  assign bias_mid = s_q.mid;
  assign bias_ground = s_q.gnd;
  assign main_rx_enable = s_q.rx_en;
  assign monitor_enable = s_q.mon_en;
  assign rxd_out = s_q.rxd;
  assign rxd_oe_n = s_q.rxd_oe_n;
  assign mode = s_q.mode;
endmodule : can_mode_wake_ctrl

// ===== verilog/state_filter_if.sv
`timescale 1ns/100ps
// filtered bus state events between the filter and the mode logic
interface state_filter_if;
  logic filt_dom;
  logic filt_rec;
  logic dom_level;
  modport source (output filt_dom, output filt_rec, output dom_level);
  modport sink (input filt_dom, input filt_rec, input dom_level);
endinterface : state_filter_if

// ===== verilog/xcvr_pkg.sv
// Contract
// - thermal shutdown disables driver and blocks transmit path to bus
// - shutdown releases when over-temperature clears; input hysteresis prevents toggling
// - during thermal shutdown bus stays mid-biased and receive path works
// - io supply low gives protected state, bus and receive output high impedance
// - main low, io valid: select high standby-wake, low protected recessive
// - after undervoltage recovery normal mode only after mode transition time
// - floating transmit input defaults recessive
// - floating standby select defaults high, giving standby
// - standby select low gives normal, high gives standby
// - normal mode: driver and receiver on, receive output follows bus
// - standby: driver off, monitor on, receive high until wake pattern
// - standby weakly pulls both bus lines to ground
// - wake detector: filtered dominant, recessive, dominant; glitches keep progress
// - wake shown as falling edge, low for the filtered dominant
// - after wake, every further filtered dominant drives receive low
// - bus state counts filtered only when longer than filter time
// - filter time short enough for one 500k bit or two 1M bits
// - pattern incomplete at wake timeout resets detector, no wake
// - dominant is logic low on transmit and receive, recessive high
// - transmit dominant longer than limit disables driver until recessive
package xcvr_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TRANSMIT_DOMINANT_LIMIT_US = 1200;
  localparam int unsigned TRANSMIT_DOMINANT_CYCLES =
    TRANSMIT_DOMINANT_LIMIT_US * (CLK_HZ / 1_000_000);
  // wake filter: 1.5 us fits inside a 2 us bit at 500k and two 1 us bits at 1M
  localparam int unsigned WAKE_FILTER_TIME_NS = 1500;
  localparam int unsigned WAKE_FILTER_CYCLES = (WAKE_FILTER_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned WAKE_WINDOW_LIMIT_US = 1000;
  localparam int unsigned WAKE_WINDOW_CYCLES = WAKE_WINDOW_LIMIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MODE_TIME_US = 20;
  localparam int unsigned MODE_CYCLES = MODE_TIME_US * (CLK_HZ / 1_000_000);
  localparam logic DOMINANT = 1'b0;
  localparam logic RECESSIVE = 1'b1;
  typedef enum logic [1:0] {
    MODE_PROTECTED, MODE_STANDBY, MODE_WAIT, MODE_NORMAL
  } mode_t;
  typedef enum logic [1:0] {
    WAKE_IDLE, WAKE_SEEK_REC, WAKE_SEEK_DOM, WAKE_DONE
  } wake_state_t;
endpackage : xcvr_pkg
